// File: sic_cache.sv
/*
  sectored instruction cache controller: tag compare, valid bits, miss refill,
  lock and flush instructions, bypass when disabled.
  assumes the fetch unit holds its request until ack, and the external memory
  port answers each read after the programmed wait count with ext_rvalid.
*/
// Behaviour
// R1: 1024 words as eight 128-word sectors
// R2: any memory sector fits any cache sector
// R3: low seven address bits pick word
// R4: upper seventeen address bits form tag
// R5: one tag register per sector
// R6: eight banks of 128 valid bits
// R7: valid means present, clear forces fetch
// R8: valid bits have no software path
// R9: reset clears all valid bits
// R10: eight parallel tag compares classify hit/miss
// R11: hit delivers stored word to fetch unit
// R12: miss starts external fetch with replacement
// R13: no tag match is a sector miss
// R14: sector miss replaces least recently used
// R15: fetches, flush, lock, unlock update LRU; the code leaves LRU unchanged on flush all
// R16: locked sectors move but are skipped
// R17: reset order sector 0 MRU, 7 LRU
// R18: enable bit from extended mode register
// R19: enabled cache storage hidden, range external
// R20: refill moves one to four words
// R21: controller status visible to debug port
// R22: flush all, lock, unlock by instruction
// R23: reset: disabled, tags ones, all unlocked
// R24: burst count four minus two LSBs
// R25: hit/refill makes MRU, sets valid
// R26: each fetch stalls wait count plus one; code stalls a hit one cycle, a miss until its last word arrives
// R27: disabled: bypass without changing cache state
`timescale 1ns/10ps
module sic_cache
  import sic_pkg::*;
#(
  parameter int SECTORS = SIC_SECTORS,
  parameter int WORDS_PER_SECTOR = SIC_WORDS_PER_SECTOR
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic extended_mode_reg_ce,
  input wire logic burst_en,
  input wire logic [SIC_WAIT_W-1:0] bus_timing_regs_wait,
  input wire logic fetch_req,
  input wire sic_pkg::sic_fetch_req_t fetch_in,
  output logic fetch_ack,
  output sic_pkg::sic_fetch_rsp_t fetch_out,
  output logic fetch_stall,
  input wire logic op_valid,
  input wire sic_pkg::sic_op_t op_code,
  input wire logic [SIC_ADDR_W-1:0] op_addr,
  output logic op_done,
  output logic op_refused,
  output logic ext_req,
  output logic [SIC_ADDR_W-1:0] ext_addr,
  input wire logic ext_rvalid,
  input wire logic [SIC_DATA_W-1:0] ext_rdata,
  output sic_pkg::sic_debug_t debug_status
);
  import sic_pkg::*;

  // ==========================================================
  // elaboration check: logic is built for the documented geometry
  if (SECTORS != SIC_SECTORS || WORDS_PER_SECTOR != SIC_WORDS_PER_SECTOR
      || SECTORS * WORDS_PER_SECTOR != SIC_WORDS)
    $error("sic_cache: only 8 sectors of 128 words are supported"); // R1

  // ==========================================================
  // state
  logic [SIC_TAG_W-1:0] tag [SIC_SECTORS]; // R5
  logic [SIC_WORDS_PER_SECTOR-1:0] valid [SIC_SECTORS]; // R6 R8
  logic [SIC_SECTORS-1:0] locked;
  sic_state_t state;
  logic [SIC_ADDR_W-1:0] cur_addr;
  logic [SIC_ADDR_W-1:0] req_addr;
  logic [SIC_WAY_W-1:0] cur_way;
  logic [2:0] words_left;
  logic [SIC_WAIT_W:0] wait_cnt;
  logic bypass;
  logic last_hit;
  logic last_smiss;

  // ==========================================================
  // address split and parallel compare
  function automatic logic [SIC_TAG_W-1:0] tag_of(input logic [SIC_ADDR_W-1:0] a);
    tag_of = a[SIC_ADDR_W-1:SIC_OFF_W]; // R4
  endfunction

  function automatic logic [SIC_OFF_W-1:0] off_of(input logic [SIC_ADDR_W-1:0] a);
    off_of = a[SIC_OFF_W-1:0]; // R3
  endfunction

  // burst length from the two low address bits
  function automatic logic [2:0] burst_len(input logic be, input logic [SIC_ADDR_W-1:0] a);
    if (be)
      burst_len = 3'(SIC_BURST_MAX) - {1'b0, a[SIC_BURST_LSB_W-1:0]}; // R24
    else
      burst_len = 3'h1;
  endfunction

  logic [SIC_SECTORS-1:0] fetch_match;
  logic [SIC_SECTORS-1:0] op_match;
  logic [SIC_WAY_W-1:0] fetch_way;
  logic [SIC_WAY_W-1:0] op_way;

  // eight comparators for the fetch and eight for an instruction operand
  always_comb
  begin
    fetch_way = '0;
    op_way = '0;
    for (int i = 0; i < SIC_SECTORS; i++)
    begin
      fetch_match[i] = (tag[i] == tag_of(fetch_in.addr)); // R10 R2
      op_match[i] = (tag[i] == tag_of(op_addr));
      if (fetch_match[i])
        fetch_way = SIC_WAY_W'(i);
      if (op_match[i])
        op_way = SIC_WAY_W'(i);
    end
  end

  logic fetch_tag_hit;
  logic fetch_word_ok;
  logic op_tag_hit;
  assign fetch_tag_hit = |fetch_match;
  assign fetch_word_ok = fetch_tag_hit && valid[fetch_way][off_of(fetch_in.addr)]; // R7
  assign op_tag_hit = |op_match;

  // ==========================================================
  // replacement unit
  logic lru_touch;
  logic [SIC_WAY_W-1:0] lru_way;
  logic [SIC_WAY_W-1:0] victim;
  logic victim_ok;

  sic_lru #(
    .WAYS(SIC_SECTORS),
    .WW(SIC_WAY_W)
  ) u_victim_select_unit (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(clk_en),
    .touch(lru_touch),
    .touch_way(lru_way),
    .locked(locked),
    .victim(victim),
    .victim_ok(victim_ok)
  );

  // ==========================================================
  // request decode in idle
  logic idle;
  logic start_fetch;
  logic start_op;
  logic alloc_needed;
  logic op_alloc;
  assign idle = (state == SIC_ST_IDLE);
  assign start_fetch = idle && fetch_req && !op_valid;
  assign start_op = idle && op_valid;
  assign alloc_needed = extended_mode_reg_ce && !fetch_tag_hit; // R13
  assign op_alloc = (op_code == SIC_OP_LOCK || op_code == SIC_OP_RELEASE) && !op_tag_hit;

  // all-locked victim refuses allocation; lock needs cache enabled
  logic op_ok;
  always_comb
  begin
    op_ok = 1'b1;
    if ((op_code == SIC_OP_LOCK || op_code == SIC_OP_RELEASE) && !extended_mode_reg_ce)
      op_ok = 1'b0;
    else if (op_alloc && !victim_ok)
      op_ok = 1'b0;
  end

  // a sector miss during fetch with every sector locked goes straight to memory
  logic sector_alloc;
  assign sector_alloc = start_fetch && alloc_needed && victim_ok;

  // LRU touched by fetches, allocation and the lock and release instructions
  always_comb
  begin
    lru_touch = 1'b0;
    lru_way = fetch_way;
    if (start_fetch && extended_mode_reg_ce)
    begin
      lru_touch = fetch_tag_hit || victim_ok; // R25 R15
      lru_way = fetch_tag_hit ? fetch_way : victim;
    end
    else if (start_op && op_ok && op_code != SIC_OP_FREE_ALL && op_code != SIC_OP_FLUSH_ALL)
    begin
      lru_touch = 1'b1; // R15
      lru_way = op_tag_hit ? op_way : victim;
    end
  end

  // ==========================================================
  // controller sequence
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= SIC_ST_IDLE;
      cur_addr <= '0;
      req_addr <= '0;
      cur_way <= '0;
      words_left <= '0;
      bypass <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state)
        SIC_ST_IDLE:
        begin
          if (start_fetch)
          begin
            cur_addr <= fetch_in.addr;
            req_addr <= fetch_in.addr;
            cur_way <= fetch_tag_hit ? fetch_way : victim;
            bypass <= !extended_mode_reg_ce || (alloc_needed && !victim_ok); // R27 R19
            if (extended_mode_reg_ce && fetch_word_ok)
              state <= SIC_ST_HIT; // R11
            else
            begin
              words_left <= (extended_mode_reg_ce && (fetch_tag_hit || victim_ok))
                ? burst_len(burst_en, fetch_in.addr) : 3'h1; // R20
              state <= SIC_ST_EXT; // R12
            end
          end
        end
        SIC_ST_HIT:
          state <= SIC_ST_IDLE;
        SIC_ST_EXT:
          state <= SIC_ST_WAIT;
        SIC_ST_WAIT:
        begin
          if (ext_rvalid)
          begin
            cur_addr <= cur_addr + SIC_ADDR_W'(1);
            words_left <= words_left - 3'h1;
            state <= (words_left == 3'h1) ? SIC_ST_IDLE : SIC_ST_EXT;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // tags and locks
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SIC_SECTORS; i++)
        tag[i] <= SIC_TAG_RESET; // R23
      locked <= SIC_LOCK_RESET; // R23
    end
    else if (clk_en)
    begin
      if (sector_alloc)
        tag[victim] <= tag_of(fetch_in.addr); // R13
      if (start_op && op_ok)
      begin
        unique case (op_code)
          SIC_OP_LOCK:
          begin
            if (op_alloc)
              tag[victim] <= tag_of(op_addr);
            locked[op_tag_hit ? op_way : victim] <= 1'b1; // R22
          end
          SIC_OP_RELEASE:
          begin
            if (op_alloc)
              tag[victim] <= tag_of(op_addr);
            locked[op_tag_hit ? op_way : victim] <= 1'b0; // R22
          end
          SIC_OP_FREE_ALL:
            locked <= SIC_LOCK_RESET;
          default:
            ;
        endcase
      end
    end
  end

  // ==========================================================
  // valid bits: cleared by reset, flush and allocation, set on refill
  logic refill_we;
  assign refill_we = (state == SIC_ST_WAIT) && ext_rvalid && !bypass;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SIC_SECTORS; i++)
        valid[i] <= SIC_VALID_RESET; // R9
    end
    else if (clk_en)
    begin
      if (start_op && op_code == SIC_OP_FLUSH_ALL)
      begin
        for (int i = 0; i < SIC_SECTORS; i++)
          valid[i] <= SIC_VALID_RESET; // R22
      end
      else if (sector_alloc)
        valid[victim] <= SIC_VALID_RESET; // R13
      else if (start_op && op_ok && op_alloc)
        valid[victim] <= SIC_VALID_RESET;
      if (refill_we)
        valid[cur_way][off_of(cur_addr)] <= 1'b1; // R25
    end
  end

  // ==========================================================
  // word storage
  logic [SIC_MEM_AW-1:0] mem_addr;
  logic [SIC_DATA_W-1:0] mem_rdata;
  assign mem_addr = refill_we ? {cur_way, off_of(cur_addr)} : {fetch_way, off_of(fetch_in.addr)};

  sic_mem #(
    .AW(SIC_MEM_AW),
    .DW(SIC_DATA_W)
  ) u_store (
    .mclk(mclk),
    .ce(clk_en),
    .we(refill_we),
    .addr(mem_addr),
    .wdata(ext_rdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // external memory port: one read per word, wait count plus one
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wait_cnt <= '0;
    else if (clk_en)
    begin
      if (state == SIC_ST_EXT)
        wait_cnt <= {1'b0, bus_timing_regs_wait} + (SIC_WAIT_W+1)'(1); // R26
      else if (state == SIC_ST_WAIT && wait_cnt != '0)
        wait_cnt <= wait_cnt - (SIC_WAIT_W+1)'(1);
    end
  end

  assign ext_req = (state == SIC_ST_EXT);
  assign ext_addr = cur_addr;

  // ==========================================================
  // answer to the fetch unit, data from flops
  logic first_word;
  assign first_word = (state == SIC_ST_WAIT) && ext_rvalid && (cur_addr == req_addr);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fetch_ack <= 1'b0;
      fetch_out <= '0;
    end
    else if (clk_en)
    begin
      fetch_ack <= 1'b0;
      if (state == SIC_ST_HIT)
      begin
        fetch_ack <= 1'b1;
        fetch_out <= '{addr: req_addr, data: mem_rdata}; // R11
      end
      else if (first_word)
      begin
        fetch_ack <= 1'b1;
        fetch_out <= '{addr: req_addr, data: ext_rdata};
      end
    end
  end

  // stall while the controller is busy, through the last word of a burst refill
  assign fetch_stall = !idle; // R26

  // instruction completion
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op_done <= 1'b0;
      op_refused <= 1'b0;
    end
    else if (clk_en)
    begin
      op_done <= start_op;
      op_refused <= start_op && !op_ok;
    end
  end

  // ==========================================================
  // debug status
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      last_hit <= 1'b0;
      last_smiss <= 1'b0;
    end
    else if (clk_en && start_fetch && extended_mode_reg_ce)
    begin
      last_hit <= fetch_word_ok;
      last_smiss <= !fetch_tag_hit;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      debug_status <= '0;
    else if (clk_en)
      debug_status <= '{enabled: extended_mode_reg_ce, busy: !idle, last_hit: last_hit,
                        last_sector_miss: last_smiss, locked: locked, victim: victim,
                        victim_ok: victim_ok}; // R21 R18
  end
endmodule

// File: sic_pkg.sv
/*
  package for the sectored instruction cache: address split, geometry, reset values,
  opcodes of cache instructions, controller states and the carrier structs.
  assumes a 24-bit program address space and 24-bit instruction words.
*/
package sic_pkg;
  // ==========================================================
  // geometry and address split
  localparam int SIC_ADDR_W = 24;
  localparam int SIC_DATA_W = 24;
  localparam int SIC_SECTORS = 8;
  localparam int SIC_WORDS_PER_SECTOR = 128;
  localparam int SIC_WORDS = SIC_SECTORS * SIC_WORDS_PER_SECTOR;
  localparam int SIC_OFF_W = 7;
  localparam int SIC_TAG_W = SIC_ADDR_W - SIC_OFF_W;
  localparam int SIC_WAY_W = 3;
  localparam int SIC_MEM_AW = SIC_WAY_W + SIC_OFF_W;
  localparam int SIC_BURST_MAX = 4;
  localparam int SIC_BURST_LSB_W = 2;
  localparam int SIC_WAIT_W = 5;

  // ==========================================================
  // reset values
  localparam logic [SIC_TAG_W-1:0] SIC_TAG_RESET = 17'h1ffff;
  localparam logic [SIC_WORDS_PER_SECTOR-1:0] SIC_VALID_RESET = 128'h0;
  localparam logic [SIC_SECTORS-1:0] SIC_LOCK_RESET = 8'h00;

  // ==========================================================
  // cache instructions from the core
  typedef enum logic [2:0] {
    SIC_OP_NONE = 3'h0,
    SIC_OP_FLUSH_ALL = 3'h1,
    SIC_OP_LOCK = 3'h2,
    SIC_OP_RELEASE = 3'h3,
    SIC_OP_FREE_ALL = 3'h4
  } sic_op_t;

  // controller states, one-hot
  typedef enum logic [3:0] {
    SIC_ST_IDLE = 4'b0001,
    SIC_ST_HIT = 4'b0010,
    SIC_ST_EXT = 4'b0100,
    SIC_ST_WAIT = 4'b1000
  } sic_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [SIC_ADDR_W-1:0] addr;
  } sic_fetch_req_t;

  typedef struct packed {
    logic [SIC_ADDR_W-1:0] addr;
    logic [SIC_DATA_W-1:0] data;
  } sic_fetch_rsp_t;

  typedef struct packed {
    logic enabled;
    logic busy;
    logic last_hit;
    logic last_sector_miss;
    logic [SIC_SECTORS-1:0] locked;
    logic [SIC_WAY_W-1:0] victim;
    logic victim_ok;
  } sic_debug_t;
endpackage

// File: sic_mem.sv
/*
  single-port word memory holding the cached instructions.
  assumes one write or one read per cycle; read data come out of a register.
*/
`timescale 1ns/10ps
module sic_mem #(
  parameter int AW = 10,
  parameter int DW = 24
)(
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  // ==========================================================
  // storage
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write or registered read
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (we)
        mem[addr] <= wdata;
      else
        rdata <= mem[addr];
    end
  end
endmodule

// File: sic_lru.sv
/*
  least recently used stack of the sectors with lock-aware victim choice.
  assumes at most one touch per cycle; stack slot 0 is the most recent.
*/
`timescale 1ns/10ps
module sic_lru
  import sic_pkg::*;
#(
  parameter int WAYS = 8,
  parameter int WW = 3
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic touch,
  input wire logic [WW-1:0] touch_way,
  input wire logic [WAYS-1:0] locked,
  output logic [WW-1:0] victim,
  output logic victim_ok
);
  // ==========================================================
  // stack, slot 0 most recent
  logic [WW-1:0] stack [WAYS];
  logic [WW-1:0] next_stack [WAYS];
  int pos;

  // move the touched sector to the top, shifting those above it down
  always_comb
  begin
    pos = 0;
    for (int i = 0; i < WAYS; i++)
      if (stack[i] == touch_way)
        pos = i;
    for (int i = 0; i < WAYS; i++)
      if (i == 0)
        next_stack[i] = touch_way;
      else if (i <= pos)
        next_stack[i] = stack[i-1];
      else
        next_stack[i] = stack[i];
  end

  // stack register, reset to 0 on top and 7 at the bottom
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < WAYS; i++)
        stack[i] <= WW'(i); // R17
    end
    else if (ce && touch)
    begin
      for (int i = 0; i < WAYS; i++)
        stack[i] <= next_stack[i]; // R15
    end
  end

  // victim: least recent sector not locked, locked ones still move
  always_comb
  begin
    victim = '0;
    victim_ok = 1'b0;
    for (int i = 0; i < WAYS; i++)
      if (!victim_ok && !locked[stack[WAYS-1-i]])
      begin
        victim = stack[WAYS-1-i]; // R14 R16
        victim_ok = 1'b1;
      end
  end
endmodule

// File: sic_cache_properties.sv
/*
  concurrent checks on the ports of the instruction cache controller.
  assumes it is bound into sic_cache and sees only that module's ports.
*/
`timescale 1ns/10ps
module sic_cache_checker
  import sic_pkg::*;
#(
  parameter int SECTORS = SIC_SECTORS,
  parameter int WORDS_PER_SECTOR = SIC_WORDS_PER_SECTOR
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic extended_mode_reg_ce,
  input wire logic fetch_req,
  input wire sic_pkg::sic_fetch_req_t fetch_in,
  input wire logic fetch_ack,
  input wire sic_pkg::sic_fetch_rsp_t fetch_out,
  input wire logic fetch_stall,
  input wire logic op_valid,
  input wire sic_pkg::sic_op_t op_code,
  input wire logic op_done,
  input wire logic op_refused,
  input wire logic ext_req,
  input wire logic [SIC_ADDR_W-1:0] ext_addr,
  input wire logic ext_rvalid,
  input wire logic [SIC_DATA_W-1:0] ext_rdata,
  input wire sic_pkg::sic_debug_t debug_status
);
  // ==========================================================
  // requests taken by an idle controller
  logic fetch_taken;
  logic op_taken;
  assign fetch_taken = rst_n && clk_en && fetch_req && !op_valid && !fetch_stall;
  assign op_taken = rst_n && clk_en && op_valid && !fetch_stall && (op_code != SIC_OP_NONE);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // properties
  property p_reset_quiet;
    disable iff (1'b0) !rst_n && clk_en |=> !fetch_ack && !ext_req && !op_done && (debug_status == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

  property p_ack_pulse;
    fetch_ack && clk_en |=> !fetch_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("fetch ack longer than one cycle");

  property p_hit_ack;
    fetch_taken ##1 (clk_en && !ext_req) |=> fetch_ack;
  endproperty
  a_hit_ack: assert property (p_hit_ack) else $error("hit not answered two cycles after request");

  property p_miss_addr;
    fetch_taken ##1 ext_req |-> ext_addr == $past(fetch_in.addr);
  endproperty
  a_miss_addr: assert property (p_miss_addr) else $error("external read at wrong address");

  property p_miss_data;
    ext_rvalid && clk_en && fetch_stall ##1 fetch_ack |-> fetch_out.data == $past(ext_rdata);
  endproperty
  a_miss_data: assert property (p_miss_data) else $error("miss data differs from memory word");

  property p_miss_bound;
    fetch_taken ##1 ext_req |-> ##[1:80] fetch_ack;
  endproperty
  a_miss_bound: assert property (p_miss_bound) else $error("miss never answered");

  property p_ext_in_stall;
    ext_req |-> fetch_stall;
  endproperty
  a_ext_in_stall: assert property (p_ext_in_stall) else $error("external read while not stalled");

  property p_op_done;
    op_taken |-> ##[1:2] op_done;
  endproperty
  a_op_done: assert property (p_op_done) else $error("cache instruction not completed");

  property p_lock_refused;
    op_taken && !extended_mode_reg_ce && (op_code inside {SIC_OP_LOCK, SIC_OP_RELEASE}) |-> ##[1:2] op_refused;
  endproperty
  a_lock_refused: assert property (p_lock_refused) else $error("lock with cache off not refused");

  property p_debug_enable;
    $past(rst_n) && $past(clk_en) |-> debug_status.enabled == $past(extended_mode_reg_ce);
  endproperty
  a_debug_enable: assert property (p_debug_enable) else $error("debug enable does not follow input");

  property p_free_all;
    op_taken && (op_code == SIC_OP_FREE_ALL) |-> ##[1:3] (debug_status.locked == '0);
  endproperty
  a_free_all: assert property (p_free_all) else $error("free all left sectors locked");
endmodule

bind sic_cache sic_cache_checker #(.SECTORS(SECTORS), .WORDS_PER_SECTOR(WORDS_PER_SECTOR)) u_checker (
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .extended_mode_reg_ce(extended_mode_reg_ce),
  .fetch_req(fetch_req), .fetch_in(fetch_in), .fetch_ack(fetch_ack), .fetch_out(fetch_out),
  .fetch_stall(fetch_stall), .op_valid(op_valid), .op_code(op_code), .op_done(op_done),
  .op_refused(op_refused), .ext_req(ext_req), .ext_addr(ext_addr), .ext_rvalid(ext_rvalid),
  .ext_rdata(ext_rdata), .debug_status(debug_status));

// File: sic_ext_mem_model.sv
/*
  external program memory model: one read at a time, answered after wait count plus one cycles.
  assumes one ext_req pulse per word and no new read before the previous answer.
*/
`timescale 1ns/10ps
module sic_ext_mem_model
  import sic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [SIC_WAIT_W-1:0] wait_count,
  input wire logic ext_req,
  input wire logic [SIC_ADDR_W-1:0] ext_addr,
  output logic ext_rvalid,
  output logic [SIC_DATA_W-1:0] ext_rdata
);
  logic pending;
  logic [SIC_ADDR_W-1:0] held_addr;
  logic [SIC_WAIT_W-1:0] cnt;

  // answer each read late by the wait count; data lines toggle while no word is offered
  always_ff @(posedge mclk)
  begin
    ext_rvalid <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (!rst_n)
    begin
      pending <= 1'b0;
      ext_rdata <= 24'h000000;
    end
    else if (ext_req)
    begin
      pending <= 1'b1;
      held_addr <= ext_addr;
      cnt <= wait_count;
    end
    else if (pending && cnt == 5'h00)
    begin
      pending <= 1'b0;
      ext_rvalid <= 1'b1;
      ext_rdata <= held_addr ^ 24'h5a3c96;
    end
    else if (pending)
      cnt <= cnt - 5'h01;
  end
endmodule

// File: tb_top.sv
/*
  self-checking testbench of the instruction cache controller with an external memory model.
  assumes the default geometry of the cache and the memory model's data pattern.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top
  import sic_pkg::*;
;
  typedef struct {logic ce; logic burst; logic [SIC_ADDR_W-1:0] addr; int n_ext;} sic_row_t;
  logic mclk, rst_n, clk_en, cache_on, burst_en, fetch_req, fetch_ack, fetch_stall;
  logic op_valid, op_done, op_refused, ext_req, ext_rvalid;
  logic [SIC_WAIT_W-1:0] wait_cnt;
  logic [SIC_ADDR_W-1:0] op_addr, ext_addr;
  logic [SIC_DATA_W-1:0] ext_rdata;
  sic_fetch_req_t fetch_in;
  sic_fetch_rsp_t fetch_out;
  sic_op_t op_code;
  sic_debug_t debug_status;
  int n_mismatch = 0;
  int num_checks = 0;
  int ack_at;
  // ordinary fetches: enable, burst, address, external reads expected
  sic_row_t rows [12] = '{'{0, 0, 24'h000010, 1}, '{1, 0, 24'h000010, 1}, '{1, 0, 24'h000010, 0},
    '{1, 1, 24'h000014, 4}, '{1, 1, 24'h000015, 0}, '{1, 1, 24'h000019, 3}, '{1, 1, 24'h000022, 2},
    '{1, 1, 24'h000027, 1}, '{1, 0, 24'h000015, 0}, '{0, 0, 24'h000014, 1}, '{1, 0, 24'h000014, 0},
    '{1, 0, 24'h000080, 1}};

  // ==========================================================
  // clock, design and memory model
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sic_cache u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .extended_mode_reg_ce(cache_on),
    .burst_en(burst_en), .bus_timing_regs_wait(wait_cnt), .fetch_req(fetch_req), .fetch_in(fetch_in),
    .fetch_ack(fetch_ack), .fetch_out(fetch_out), .fetch_stall(fetch_stall), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_done(op_done), .op_refused(op_refused), .ext_req(ext_req),
    .ext_addr(ext_addr), .ext_rvalid(ext_rvalid), .ext_rdata(ext_rdata), .debug_status(debug_status));

  sic_ext_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .wait_count(wait_cnt), .ext_req(ext_req),
    .ext_addr(ext_addr), .ext_rvalid(ext_rvalid), .ext_rdata(ext_rdata));
  // ==========================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("victim", 3'h7, debug_status.victim)
    `CHK("locked", 8'h00, debug_status.locked)
    `CHK("enabled", 1'b0, debug_status.enabled)
  endtask

  // hold a fetch until acked, count external reads
  task automatic do_fetch(input logic [SIC_ADDR_W-1:0] a, input int n_ext);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    @(negedge mclk);
    fetch_req = 1'b1;
    fetch_in.addr = a;
    while ((fetch_req || fetch_stall) && guard < 200)
    begin
      @(negedge mclk);
      guard++;
      if (ext_req)
      begin
        `CHK("ext_addr", a + seen, ext_addr)
        seen++;
      end
      if (fetch_ack && fetch_req)
      begin
        `CHK("fetch data", a ^ 24'h5a3c96, fetch_out.data)
        `CHK("fetch addr", a, fetch_out.addr)
        fetch_req = 1'b0;
        ack_at = guard;
      end
    end
    `CHK("ext reads", n_ext, seen)
  endtask

  task automatic do_op(input sic_op_t code, input logic [SIC_ADDR_W-1:0] a, input logic exp_ref);
    int guard;
    guard = 0;
    @(negedge mclk);
    op_valid = 1'b1;
    op_code = code;
    op_addr = a;
    @(negedge mclk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && guard < 4)
    begin
      @(negedge mclk);
      guard++;
    end
    `CHK("op_done", 1'b1, op_done)
    `CHK("op_refused", exp_ref, op_refused)
  endtask
  // ==========================================================
  // watchdog
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {rst_n, cache_on, burst_en, fetch_req, op_valid} = 5'h00;
    clk_en = 1'b1;
    wait_cnt = 5'h02;
    fetch_in = '0;
    op_code = SIC_OP_NONE;
    op_addr = 24'h000000;
    do_reset();
    foreach (rows[i])
    begin
      cache_on = rows[i].ce;
      burst_en = rows[i].burst;
      do_fetch(rows[i].addr, rows[i].n_ext);
    end
    cache_on = 1'b0;
    do_op(SIC_OP_LOCK, 24'h001000, 1'b1);
    cache_on = 1'b1;
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 8; k++)
      do_op(SIC_OP_LOCK, 24'h001000 + k * 128, 1'b0);
    repeat (2) @(negedge mclk);
    `CHK("all locked", 8'hff, debug_status.locked)
    `CHK("no victim", 1'b0, debug_status.victim_ok)
    do_op(SIC_OP_LOCK, 24'h002000, 1'b1);
    do_op(SIC_OP_RELEASE, 24'h002000, 1'b1);
    do_fetch(24'h002000, 1);
    do_fetch(24'h002000, 1);
    do_fetch(24'h001005, 1);
    do_fetch(24'h001005, 0);
    do_op(SIC_OP_RELEASE, 24'h001000, 1'b0);
    repeat (2) @(negedge mclk);
    `CHK("victim back", 1'b1, debug_status.victim_ok)
    do_fetch(24'h002000, 1);
    do_fetch(24'h002000, 0);
    do_op(SIC_OP_FLUSH_ALL, 24'h000000, 1'b0);
    do_fetch(24'h002000, 1);
    wait_cnt = 5'h00;
    do_fetch(24'h002011, 1);
    `CHK("stall span", 4, ack_at)
    wait_cnt = 5'h1f;
    do_fetch(24'h002012, 1);
    `CHK("stall span", 35, ack_at)
    // free all sectors, first held off by a frozen clock enable
    @(negedge mclk);
    clk_en = 1'b0;
    op_valid = 1'b1;
    op_code = SIC_OP_FREE_ALL;
    repeat (3) @(negedge mclk);
    `CHK("frozen op", 1'b0, op_done)
    clk_en = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("locks freed", 8'h00, debug_status.locked)
    // second reset in mid-run: cache off and empty again, victim order restarts
    cache_on = 1'b0;
    do_reset();
    cache_on = 1'b1;
    do_fetch(24'h002000, 1);
    repeat (2) @(negedge mclk);
    `CHK("next victim", 3'h6, debug_status.victim)
    `CHK("sector miss seen", 1'b1, debug_status.last_sector_miss)
    complete_run();
  end
endmodule
